// file: logic/spi_eeprom_write_read_protect.sv
// Command execution of the serial nonvolatile byte memory
`timescale 1ns/10ps
`include "eeprom_cfg.svh"

module spi_eeprom_write_read_protect #(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic program_busy
);

  generate
    if (PROG_CYCLES < `PAGE_BYTES)
    begin : g_bad
      $error("PROG_CYCLES must cover the page commit walk");
    end
  endgenerate

  link_if l ();
  prog_if p ();

  eeprom_pkg::frame_state_t state_q;
  eeprom_pkg::frame_state_t op_next;
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [`ADDR_W-1:0] addr_q;
  logic is_read_q;
  logic armed_q;
  logic [7:0] sr_new_q;
  logic sr_pend_q;
  logic pin_protect_enable_q;
  logic block_protect_sel_hi_q;
  logic block_protect_sel_lo_q;
  logic wel_q;
  logic [7:0] status_byte;
  logic [7:0] out_sh_q;
  logic [2:0] out_cnt_q;
  logic so_q;
  logic so_oe_q;
  logic op_valid;
  logic op_end;
  logic addr_end;
  logic wl_set;
  logic wl_clr;
  logic launch_arr;
  logic launch_sr;
  logic [7:0] mem_q [0:`MEM_BYTES-1];
  logic [7:0] page_q [0:`PAGE_BYTES-1];
  logic [`PAGE_BYTES-1:0] page_vld_q;
  logic commit_q;
  logic [`PAGE_W-1:0] commit_idx_q;
  logic [`ADDR_W-`PAGE_W-1:0] page_base_q;
  logic [`ADDR_W-1:0] commit_addr;
  logic [`ADDR_W-1:0] prot_base;
  logic prot_any;
  logic [`ADDR_W-1:0] rd_next_addr;

  link_sampler u_link (
    .mclk(mclk),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .wp_n(wp_n),
    .l(l.src)
  );

  prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .p(p.timer)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign shift_d = {shift_q[14:0], l.si};
  assign op_valid = shift_d[7:4] == 4'h0;
  assign op_end = l.sck_rise && state_q == eeprom_pkg::ST_OPCODE && bit_cnt_q == 4'h7;
  assign addr_end = l.sck_rise && state_q == eeprom_pkg::ST_ADDR && bit_cnt_q == 4'hF;
  assign rd_next_addr = addr_q + `ADDR_W'(1);

  always_comb
  begin
    op_next = eeprom_pkg::ST_SKIP;
    if (op_valid)
    begin
      case (shift_d[2:0])
        `OP_READ: op_next = p.busy ? eeprom_pkg::ST_SKIP : eeprom_pkg::ST_ADDR;
        `OP_WRITE: op_next = (p.busy || !wel_q) ? eeprom_pkg::ST_SKIP
          : eeprom_pkg::ST_ADDR;
        `OP_SR_RD: op_next = eeprom_pkg::ST_SR_OUT;
        `OP_SR_WR: op_next = p.busy ? eeprom_pkg::ST_SKIP : eeprom_pkg::ST_SR_IN;
        default: op_next = eeprom_pkg::ST_SKIP;
      endcase
    end
  end

  assign wl_set = op_end && op_valid && !p.busy && shift_d[2:0] == `OP_SET_WL;
  assign wl_clr = op_end && op_valid && !p.busy && shift_d[2:0] == `OP_CLR_WL;

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_q <= eeprom_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      addr_q <= `ADDR_W'h0;
      is_read_q <= 1'b0;
      armed_q <= 1'b0;
      sr_new_q <= 8'h00;
    end
    else if (!l.cs_low)
    begin
      state_q <= eeprom_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      armed_q <= 1'b0;
    end
    else if (state_q == eeprom_pkg::ST_IDLE)
    begin
      state_q <= eeprom_pkg::ST_OPCODE;
      bit_cnt_q <= 4'h0;
    end
    else if (l.sck_rise)
    begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_q + 4'h1;
      armed_q <= 1'b0;
      case (state_q)
        eeprom_pkg::ST_OPCODE:
        begin
          if (bit_cnt_q == 4'h7)
          begin
            state_q <= op_next;
            is_read_q <= shift_d[2:0] == `OP_READ;
            bit_cnt_q <= 4'h0;
          end
        end
        eeprom_pkg::ST_ADDR:
        begin
          if (bit_cnt_q == 4'hF)
          begin
            addr_q <= shift_d[`ADDR_W-1:0];
            state_q <= is_read_q ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_WDATA;
          end
        end
        eeprom_pkg::ST_WDATA:
        begin
          if (bit_cnt_q == 4'h7)
          begin
            addr_q[`PAGE_W-1:0] <= addr_q[`PAGE_W-1:0] + `PAGE_W'(1);
            armed_q <= 1'b1;
            bit_cnt_q <= 4'h0;
          end
        end
        eeprom_pkg::ST_SR_IN:
        begin
          if (bit_cnt_q == 4'h7)
          begin
            sr_new_q <= shift_d[7:0];
            armed_q <= 1'b1;
            bit_cnt_q <= 4'h0;
          end
        end
        default:
        begin
          bit_cnt_q <= 4'h0;
        end
      endcase
    end
    else if (l.sck_fall && state_q == eeprom_pkg::ST_RDATA && out_cnt_q == 3'h7)
    begin
      addr_q <= rd_next_addr;
    end
  end

  // ------------------------------------------------------------
  // Launch of programming at select release
  // ------------------------------------------------------------
  assign launch_arr = l.cs_rise && state_q == eeprom_pkg::ST_WDATA && armed_q;
  assign launch_sr = l.cs_rise && state_q == eeprom_pkg::ST_SR_IN && armed_q && wel_q
    && (l.wp_n || !pin_protect_enable_q);
  assign p.start = launch_arr || launch_sr;

  // ------------------------------------------------------------
  // Status register and write latch
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wel_q <= 1'b0;
    end
    else if (wl_set)
    begin
      wel_q <= 1'b1;
    end
    else if (wl_clr || p.done)
    begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_protect_enable_q <= `PPE_RESET;
      block_protect_sel_hi_q <= 1'(`BP_RESET >> 1);
      block_protect_sel_lo_q <= 1'(`BP_RESET);
      sr_pend_q <= 1'b0;
    end
    else if (launch_sr)
    begin
      sr_pend_q <= 1'b1;
    end
    else if (p.done && sr_pend_q)
    begin
      sr_pend_q <= 1'b0;
      pin_protect_enable_q <= sr_new_q[`SR_PPE_BIT];
      block_protect_sel_hi_q <= sr_new_q[`SR_BP_HI_BIT];
      block_protect_sel_lo_q <= sr_new_q[`SR_BP_LO_BIT];
    end
  end

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`SR_PPE_BIT] = pin_protect_enable_q;
    status_byte[`SR_BP_HI_BIT] = block_protect_sel_hi_q;
    status_byte[`SR_BP_LO_BIT] = block_protect_sel_lo_q;
    status_byte[`SR_WL_BIT] = wel_q;
    status_byte[`SR_BUSY_BIT] = p.busy;
    if (p.busy)
    begin
      status_byte = `SR_BUSY_READ;
    end
  end

  // ------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      out_sh_q <= 8'h00;
      out_cnt_q <= 3'h0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else if (!l.cs_low)
    begin
      out_cnt_q <= 3'h0;
      so_oe_q <= 1'b0;
    end
    else if (addr_end && is_read_q)
    begin
      out_sh_q <= mem_q[shift_d[`ADDR_W-1:0]];
      out_cnt_q <= 3'h0;
    end
    else if (op_end && op_next == eeprom_pkg::ST_SR_OUT)
    begin
      out_sh_q <= status_byte;
      out_cnt_q <= 3'h0;
    end
    else if (l.sck_fall && (state_q == eeprom_pkg::ST_RDATA
      || state_q == eeprom_pkg::ST_SR_OUT))
    begin
      so_q <= out_sh_q[7];
      so_oe_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q != 3'h7)
      begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
      else if (state_q == eeprom_pkg::ST_RDATA)
      begin
        out_sh_q <= mem_q[rd_next_addr];
      end
      else
      begin
        out_sh_q <= status_byte;
      end
    end
  end

  // ------------------------------------------------------------
  // Page buffer
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      page_vld_q <= '0;
    end
    else if (addr_end && !is_read_q)
    begin
      page_vld_q <= '0;
    end
    else if (l.cs_low && l.sck_rise && state_q == eeprom_pkg::ST_WDATA && bit_cnt_q == 4'h7)
    begin
      page_q[addr_q[`PAGE_W-1:0]] <= shift_d[7:0];
      page_vld_q[addr_q[`PAGE_W-1:0]] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Array commit and block protection
  // ------------------------------------------------------------
  always_comb
  begin
    prot_any = 1'b1;
    prot_base = `PROT_ALL_BASE;
    case ({block_protect_sel_hi_q, block_protect_sel_lo_q})
      2'h1: prot_base = `PROT_QUARTER_BASE;
      2'h2: prot_base = `PROT_HALF_BASE;
      2'h3: prot_base = `PROT_ALL_BASE;
      default: prot_any = 1'b0;
    endcase
  end

  assign commit_addr = {page_base_q, commit_idx_q};

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      commit_q <= 1'b0;
      commit_idx_q <= `PAGE_W'h0;
      page_base_q <= '0;
    end
    else if (launch_arr)
    begin
      commit_q <= 1'b1;
      commit_idx_q <= `PAGE_W'h0;
      page_base_q <= addr_q[`ADDR_W-1:`PAGE_W];
    end
    else if (commit_q)
    begin
      commit_idx_q <= commit_idx_q + `PAGE_W'(1);
      if (commit_idx_q == `PAGE_W'(`PAGE_BYTES - 1))
      begin
        commit_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (commit_q && page_vld_q[commit_idx_q]
      && !(prot_any && commit_addr >= prot_base))
    begin
      mem_q[commit_addr] <= page_q[commit_idx_q];
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign so = so_q;
  assign so_oe = so_oe_q;
  assign program_busy = p.busy;

endmodule

// file: logic/eeprom_cfg.svh
// Constants of the serial nonvolatile byte memory block
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define ADDR_W 15
`define PAGE_W 6
`define MEM_BYTES 32768
`define PAGE_BYTES 64

`define OP_READ 3'h3
`define OP_WRITE 3'h2
`define OP_SET_WL 3'h6
`define OP_CLR_WL 3'h4
`define OP_SR_RD 3'h5
`define OP_SR_WR 3'h1

`define SR_PPE_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_WL_BIT 1
`define SR_BUSY_BIT 0
`define SR_BUSY_READ 8'hFF

`define PPE_RESET 1'h0
`define BP_RESET 2'h0

`define PROT_QUARTER_BASE 15'h6000
`define PROT_HALF_BASE 15'h4000
`define PROT_ALL_BASE 15'h0000

`define CLK_PERIOD_NS 40
`define PROG_TIME_NS 5000000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: logic/eeprom_pkg.sv
// Types of the serial nonvolatile byte memory block
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_SR_OUT = 3'b101,
    ST_SR_IN = 3'b110,
    ST_SKIP = 3'b111
  } frame_state_t;

endpackage

// file: logic/eeprom_if.sv
// Internal carriers: sampled link and programming timer
`timescale 1ns/10ps

interface link_if;
  logic cs_low;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic wp_n;

  modport src (output cs_low, output cs_rise, output sck_rise, output sck_fall,
    output si, output wp_n);
  modport dst (input cs_low, input cs_rise, input sck_rise, input sck_fall,
    input si, input wp_n);
endinterface

interface prog_if;
  logic start;
  logic busy;
  logic done;

  modport timer (input start, output busy, output done);
  modport ctrl (output start, input busy, input done);
endinterface

// file: logic/link_sampler.sv
// Synchroniser and edge finder for the serial link pins
`timescale 1ns/10ps

module link_sampler (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  link_if.src l
);

  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic cs_n_last_q;
  logic sck_last_q;

  assign pin_in = {wp_n, si, sck, cs_n};

  // ------------------------------------------------------------
  // Two-stage synchronisers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          sync1_q[g] <= (g == 1) ? 1'b0 : 1'b1;
          sync2_q[g] <= (g == 1) ? 1'b0 : 1'b1;
        end
        else
        begin
          sync1_q[g] <= pin_in[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Edge history
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cs_n_last_q <= 1'b1;
      sck_last_q <= 1'b0;
    end
    else
    begin
      cs_n_last_q <= sync2_q[0];
      sck_last_q <= sync2_q[1];
    end
  end

  assign l.cs_low = !sync2_q[0];
  assign l.cs_rise = sync2_q[0] && !cs_n_last_q;
  assign l.sck_rise = sync2_q[1] && !sck_last_q && !sync2_q[0];
  assign l.sck_fall = !sync2_q[1] && sck_last_q && !sync2_q[0];
  assign l.si = sync2_q[2];
  assign l.wp_n = sync2_q[3];

endmodule

// file: logic/prog_timer.sv
// Self-timed programming cycle timer
`timescale 1ns/10ps

module prog_timer #(
  parameter int CYCLES = 125000
) (
  input wire logic mclk,
  input wire logic resetn,
  prog_if.timer p
);

  logic [31:0] count_q;
  logic busy_q;
  logic done_q;

  generate
    if (CYCLES < 1)
    begin : g_bad
      $error("prog_timer: CYCLES must be at least 1");
    end
  endgenerate

  // ------------------------------------------------------------
  // Busy window and completion pulse
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      count_q <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (p.start && !busy_q)
      begin
        busy_q <= 1'b1;
        count_q <= 32'(CYCLES - 1);
      end
      else if (busy_q)
      begin
        if (count_q == 32'h0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          count_q <= count_q - 32'h1;
        end
      end
    end
  end

  assign p.busy = busy_q;
  assign p.done = done_q;

endmodule

// file: bench/spi_master_model.sv
// Serial bus master model driving command frames
`timescale 1ns/10ps

module spi_master_model (
  input wire logic mclk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si
);
  // ----
  // Frame tasks
  // ----
  initial
  begin
    cs_n = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end

  task automatic start();
    @(posedge mclk);
    cs_n <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si <= tx[i];
      repeat (4) @(posedge mclk);
      sck <= 1'h1;
      repeat (3) @(posedge mclk);
      rx[i] = so;
      @(posedge mclk);
      sck <= 1'h0;
    end
  endtask

  task automatic stop();
    @(posedge mclk);
    cs_n <= 1'h1;
    si <= ~si;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// file: bench/spi_eeprom_write_read_protect_chk.sv
// Port checker for the serial memory command block
`timescale 1ns/10ps

module spi_eeprom_write_read_protect_chk #(
  parameter int PROG_CYCLES = 125000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic program_busy
);
  // ----
  // Busy length counter
  // ----
  int busy_cnt_q;

  always_ff @(posedge mclk)
  begin
    if (!resetn || !program_busy)
      busy_cnt_q <= 0;
    else
      busy_cnt_q <= busy_cnt_q + 1;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // ----
  // Assertions
  // ----
  reset_quiet_a: assert property ($rose(resetn) |-> !so_oe && !program_busy)
    else $error("outputs active after reset");
  oe_cs_high_a: assert property (cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
  oe_rise_a: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n))
    else $error("output enabled without select");
  oe_fall_a: assert property ($fell(so_oe) |-> cs_n && $past(cs_n))
    else $error("output released inside frame");
  busy_start_a: assert property ($rose(program_busy) |-> cs_n && $past(cs_n, 2))
    else $error("programming began before select release");
  busy_len_a: assert property ($fell(program_busy) |-> busy_cnt_q == PROG_CYCLES)
    else $error("programming length wrong");
  busy_ones_a: assert property (program_busy && so_oe |-> so)
    else $error("status not all ones while busy");
  so_hold_a: assert property (sck && $past(sck) && $past(sck, 2) && $past(so_oe)
    |-> $stable(so))
    else $error("output changed while clock high");
endmodule

bind spi_eeprom_write_read_protect spi_eeprom_write_read_protect_chk #(
  .PROG_CYCLES(PROG_CYCLES)
) chk (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
  .so(so), .so_oe(so_oe), .program_busy(program_busy));

// file: bench/spi_eeprom_write_read_protect_tb.sv
// Self-checking bench for the serial memory command block
`timescale 1ns/10ps

module spi_eeprom_write_read_protect_tb;
  localparam int PROG = 600;
  logic mclk = 1'h0;
  logic resetn;
  logic wp_n;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_bus;
  logic so_oe;
  logic program_busy;
  logic [7:0] mem_e [0:32767];
  logic [14:0] addr_l [6] = '{15'h0000, 15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
  logic [14:0] pa;
  logic ppe_e;
  logic [1:0] bp_e;
  logic wl_e;
  logic [7:0] rx;
  int miscompares = 0;
  int checks_done = 0;
  int seed_v;

  always #20 mclk = ~mclk;

  // Released line shows the inverse of the last bit
  assign so_bus = so_oe ? so : !so;

  spi_master_model m (.mclk(mclk), .so(so_bus), .cs_n(cs_n), .sck(sck), .si(si));
  spi_eeprom_write_read_protect #(.PROG_CYCLES(PROG)) uut (.mclk(mclk), .resetn(resetn),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .program_busy(program_busy));

  // ----
  // Expectation and compare helpers
  // ----
  function automatic logic prot(input logic [14:0] a, input logic [1:0] bp);
    case (bp)
      2'h1: return a >= 15'h6000;
      2'h2: return a >= 15'h4000;
      2'h3: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction

  function automatic logic [7:0] sr_e();
    return {ppe_e, 3'h0, bp_e, wl_e, 1'h0};
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask

  task automatic cmd(input logic [7:0] op);
    m.start();
    m.xbyte(op, rx);
    m.stop();
  endtask

  task automatic status_read_cmd_chk(input logic [7:0] e);
    m.start();
    m.xbyte(8'h05, rx);
    m.xbyte(8'($urandom), rx);
    m.stop();
    chk8("status", e, rx);
  endtask

  task automatic finish_prog(input logic go);
    int n;
    chk1("busy", go, program_busy);
    if (go)
    begin
      m.start();
      m.xbyte(8'h03, rx);
      m.xbyte(8'h00, rx);
      m.xbyte(8'h00, rx);
      m.xbyte(8'h00, rx);
      chk1("read while busy", 1'h0, so_oe);
      m.stop();
      status_read_cmd_chk(8'hFF);
      n = 0;
      while (program_busy === 1'h1 && n < 800)
      begin
        @(posedge mclk);
        n++;
      end
      chk1("busy end", 1'h0, program_busy);
      wl_e = 1'h0;
    end
  endtask

  task automatic wr(input logic [14:0] a, input int n);
    logic [7:0] d;
    logic [14:0] p;
    cmd(8'h06);
    m.start();
    m.xbyte(8'h02, rx);
    m.xbyte({1'h1, a[14:8]}, rx);
    m.xbyte(a[7:0], rx);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      p = {a[14:6], 6'(a[5:0] + i)};
      if (!prot(p, bp_e))
        mem_e[p] = d;
      m.xbyte(d, rx);
    end
    m.stop();
    finish_prog(1'h1);
    status_read_cmd_chk(sr_e());
  endtask

  task automatic rd_chk(input logic [14:0] a, input int n);
    m.start();
    m.xbyte(8'h03, rx);
    m.xbyte({1'h0, a[14:8]}, rx);
    m.xbyte(a[7:0], rx);
    for (int i = 0; i < n; i++)
    begin
      m.xbyte(8'($urandom), rx);
      chk8("read data", mem_e[15'(a + i)], rx);
    end
    m.stop();
  endtask

  task automatic sw(input logic [7:0] v, input logic go);
    cmd(8'h06);
    wl_e = 1'h1;
    m.start();
    m.xbyte(8'h01, rx);
    m.xbyte(v, rx);
    m.stop();
    finish_prog(go);
    if (go)
    begin
      ppe_e = v[7];
      bp_e = v[3:2];
    end
    status_read_cmd_chk(sr_e());
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----
  // Test sequence
  // ----
  initial
  begin
    resetn = 1'h0;
    wp_n = 1'h1;
    ppe_e = 1'h0;
    bp_e = 2'h0;
    wl_e = 1'h0;
    seed_v = $urandom(32'hB65C);
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    repeat (6) @(posedge mclk);
    status_read_cmd_chk(sr_e());
    cmd(8'h0E);
    wl_e = 1'h1;
    status_read_cmd_chk(sr_e());
    cmd(8'h04);
    wl_e = 1'h0;
    status_read_cmd_chk(sr_e());
    cmd(8'h86);
    status_read_cmd_chk(sr_e());
    $display("test latch commands done");
    m.start();
    m.xbyte(8'h02, rx);
    m.xbyte(8'h00, rx);
    m.xbyte(8'h00, rx);
    m.xbyte(8'h5A, rx);
    m.stop();
    finish_prog(1'h0);
    m.start();
    m.xbyte(8'h01, rx);
    m.xbyte(8'h8C, rx);
    m.stop();
    finish_prog(1'h0);
    status_read_cmd_chk(sr_e());
    $display("test write without latch done");
    for (int b = 0; b < 4; b++)
    begin
      sw({4'h0, 2'(b), 2'h0}, 1'h1);
      foreach (addr_l[k])
        wr(addr_l[k], 1);
      foreach (addr_l[k])
        rd_chk(addr_l[k], 1);
    end
    rd_chk(15'h7FFF, 2);
    $display("test block protect done");
    sw(8'h00, 1'h1);
    pa = {9'($urandom), 6'h3E};
    wr(pa, 66);
    rd_chk({pa[14:6], 6'h00}, 64);
    $display("test page wrap done");
    sw(8'h84, 1'h1);
    wp_n <= 1'h0;
    sw(8'h00, 1'h0);
    wr(15'h6000, 1);
    wr(15'h0040, 1);
    rd_chk(15'h6000, 1);
    rd_chk(15'h0040, 1);
    wp_n <= 1'h1;
    sw(8'h00, 1'h1);
    $display("test pin protect done");
    cmd(8'h06);
    resetn <= 1'h0;
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    repeat (6) @(posedge mclk);
    wl_e = 1'h0;
    ppe_e = 1'h0;
    bp_e = 2'h0;
    status_read_cmd_chk(sr_e());
    $display("test mid-run reset done");
    final_report();
  end

  initial
  begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    final_report();
  end
endmodule
